// ===== rtl/adc_seq_pkg.sv
// constants shared by the conversion sequencer and its result fifo
// assumes a single 20 MHz reference clock
package adc_seq_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int RESULT_WIDTH = 24;
  localparam int FIFO_DEPTH = 16;
  // serial clock low timeout, milliseconds
  localparam int SCLK_TIMEOUT_MS = 28;
  localparam int SCLK_TIMEOUT_CYC = SCLK_TIMEOUT_MS * (CLK_HZ / 1000);
  // power-up time before a single conversion, microseconds
  localparam int POWERUP_US = 25;
  localparam int POWERUP_CYC = POWERUP_US * (CLK_HZ / 1_000_000);
  // data-rate selection codes 0..7 for 6.25 .. 1000 samples per second
  localparam int RATE_CODES = 8;
  localparam logic [2:0] RATE_RESET = 3'h4;
  localparam logic MODE_RESET = 1'b1;
  // conversion period in cycles, 1/DR at 20 MHz
  function automatic logic [22:0] rate_cycles(input logic [2:0] code);
    unique case (code)
      3'h0: rate_cycles = 23'd3200000;
      3'h1: rate_cycles = 23'd1600000;
      3'h2: rate_cycles = 23'd800000;
      3'h3: rate_cycles = 23'd400000;
      3'h4: rate_cycles = 23'd200000;
      3'h5: rate_cycles = 23'd80000;
      3'h6: rate_cycles = 23'd40000;
      3'h7: rate_cycles = 23'd20000;
    endcase
  endfunction : rate_cycles
endpackage : adc_seq_pkg

// ===== rtl/result_fifo.sv
// small synchronous fifo holding conversion results
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] count;
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [WIDTH-1:0] headData;
  logic headValid;
  wire push = inValid && inReady;
  wire memNotEmpty = (count != '0);
  wire pop = memNotEmpty && (!headValid || outReady);
  wire headTaken = headValid && outReady;
  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = headValid;
  assign outData = headData;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= '0;
      wrPtr <= '0;
      rdPtr <= '0;
      headValid <= 1'b0;
      headData <= '0;
    end else begin
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
        headData <= mem[rdPtr];
        headValid <= 1'b1;
      end else if (headTaken) begin
        headValid <= 1'b0;
      end
    end
  end
endmodule : result_fifo

// ===== rtl/adc_conversion_sequencer.sv
// conversion sequencer: single and continuous modes, result register,
// result fifo toward the serial side and serial clock low timeout
// assumes modulator bits arrive synchronous to ref_clk; serial pins async
//
// Operation
// - the serial logic resets when the serial clock stays low past 28 ms.
// - in single mode a request gives one conversion, stores it, powers down.
// - in continuous mode the next conversion starts as one finishes.
// - continuous conversions complete at the programmed data rate.
// - the result is readable at any time and shows the latest conversion.
// - results are 24-bit two's-complement from a decimation filter.
// - mode bit 1 selects single mode powered down, 0 continuous.
// - a start write powers up in 25 us, clears the start bit, converts.
// - a start request during a conversion is ignored.
// - new settings apply from the next conversion, not the current one.
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int TIMEOUT_CYC = SCLK_TIMEOUT_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // configuration
  input wire logic singleMode,
  input wire logic [2:0] rateSel,
  input wire logic startWrite,
  output logic single_conversion_start,
  // modulator bitstream
  input wire logic modBit,
  // result
  output logic [RESULT_WIDTH-1:0] convResult,
  output logic result_ready_low,
  output logic poweredUp,
  output logic converting,
  // result stream toward the serial shifter
  output logic resValid,
  input wire logic resReady,
  output logic [RESULT_WIDTH-1:0] resData,
  output logic resDropped,
  // serial pins
  input wire logic sclkPin,
  input wire logic csLowPin,
  output logic serialReset
);
  typedef enum logic [1:0] {IDLE, POWERUP, CONVERT} seq_state_type;
  seq_state_type state;
  seq_state_type next_state;

  // -------------------------------------------------------------
  // serial pin synchronisers and low timeout
  // -------------------------------------------------------------
  logic sclkMeta, sclkSync, sclkPrev;
  logic csMeta, csSync;
  logic [31:0] lowCount;
  always_ff @(posedge ref_clk) begin
    sclkMeta <= sclkPin;
    sclkSync <= sclkMeta;
    sclkPrev <= sclkSync;
    csMeta <= csLowPin;
    csSync <= csMeta;
  end
  // cs is synchronised for the ready-flag clear on an sclk rise; a held-low cs is legal
  wire sclkRise = sclkSync && !sclkPrev;
  wire timeoutHit = !sclkSync && (lowCount >= 32'(TIMEOUT_CYC));
  // the counter parks at the limit, so this is true for one cycle only
  wire timeoutEdge = !sclkSync && (lowCount == 32'(TIMEOUT_CYC - 1));
  always_ff @(posedge ref_clk) begin
    if (rst || sclkRise || sclkSync) begin
      lowCount <= '0;
    end else if (!timeoutHit) begin
      lowCount <= lowCount + 32'd1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serialReset <= 1'b0;
    end else begin
      serialReset <= timeoutEdge;
    end
  end

  // -------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------
  logic [22:0] periodCnt;
  logic [22:0] activePeriod;
  logic [15:0] pupCnt;
  logic startPend;
  logic convDone;
  wire periodEnd = (state == CONVERT) && (periodCnt == activePeriod - 23'd1);
  wire newStart = startWrite && (state != CONVERT) && (state != POWERUP);

  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        if (!singleMode) begin
          next_state = CONVERT;
        end else if (startPend) begin
          next_state = POWERUP;
        end
      end
      POWERUP: begin
        if (pupCnt == 16'(POWERUP_CYC - 1)) begin
          next_state = CONVERT;
        end
      end
      CONVERT: begin
        if (periodEnd) begin
          next_state = singleMode ? IDLE : CONVERT;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= IDLE;
      startPend <= 1'b0;
      pupCnt <= '0;
      periodCnt <= '0;
      activePeriod <= rate_cycles(RATE_RESET);
    end else begin
      state <= next_state;
      if (newStart) begin
        startPend <= 1'b1;
      end else if (next_state == CONVERT) begin
        // also drops a start left pending when continuous mode took over
        startPend <= 1'b0;
      end
      pupCnt <= (state == POWERUP) ? pupCnt + 16'd1 : '0;
      // settings are latched only at a conversion boundary
      if (next_state == CONVERT && (state != CONVERT || periodEnd)) begin
        activePeriod <= rate_cycles(rateSel);
        periodCnt <= '0;
      end else if (state == CONVERT) begin
        periodCnt <= periodCnt + 23'd1;
      end
    end
  end
  assign single_conversion_start = startPend;
  assign poweredUp = (state != IDLE);
  assign converting = (state == CONVERT);

  // -------------------------------------------------------------
  // decimation: signed bit count over one conversion period
  // -------------------------------------------------------------
  logic signed [RESULT_WIDTH-1:0] acc;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc <= '0;
      convResult <= '0;
      convDone <= 1'b0;
      result_ready_low <= 1'b1;
    end else begin
      convDone <= periodEnd;
      if (periodEnd) begin
        acc <= '0;
        convResult <= acc;
        result_ready_low <= 1'b0;
      end else begin
        if (state == CONVERT) begin
          acc <= modBit ? acc + 24'sd1 : acc - 24'sd1;
        end
        if (sclkRise && !csSync) begin
          result_ready_low <= 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // result fifo; a full fifo drops the newest word, register still updates
  // -------------------------------------------------------------
  logic fifoReady;
  result_fifo #(.WIDTH(RESULT_WIDTH), .DEPTH(DEPTH)) u_result_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(convDone),
    .inReady(fifoReady),
    .inData(convResult),
    .outValid(resValid),
    .outReady(resReady),
    .outData(resData)
  );
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      resDropped <= 1'b0;
    end else begin
      resDropped <= convDone && !fifoReady;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  sequence s_startSeen;
    (state == IDLE) && singleMode && startPend;
  endsequence
  a_start_powerup: assert property (@(posedge ref_clk) disable iff (rst)
    s_startSeen |=> (state == POWERUP))
    else $error("start did not power up");
  a_pup_length: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state == POWERUP) |-> (state == POWERUP) [*8])
    else $error("power-up too short");
  a_single_down: assert property (@(posedge ref_clk) disable iff (rst)
    periodEnd && singleMode |=> (state == IDLE))
    else $error("single mode did not power down");
  a_cont_restart: assert property (@(posedge ref_clk) disable iff (rst)
    periodEnd && !singleMode |=> (state == CONVERT) && (periodCnt == 0))
    else $error("continuous mode did not restart");
  a_result_store: assert property (@(posedge ref_clk) disable iff (rst)
    periodEnd |=> (convResult == $past(acc)) && !result_ready_low)
    else $error("result not stored");
  a_ignore_start: assert property (@(posedge ref_clk) disable iff (rst)
    (state == CONVERT) && !startPend |=> !startPend)
    else $error("start accepted during conversion");
  a_period_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (state == CONVERT) && !periodEnd |=> $stable(activePeriod))
    else $error("settings changed mid conversion");
  a_rate_load: assert property (@(posedge ref_clk) disable iff (rst)
    periodEnd && !singleMode |=> activePeriod == rate_cycles($past(rateSel)))
    else $error("rate not applied");
  a_low_restart: assert property (@(posedge ref_clk) disable iff (rst)
    sclkRise |=> (lowCount == 0) && !serialReset)
    else $error("low counter not restarted");
  a_timeout_fire: assert property (@(posedge ref_clk) disable iff (rst)
    serialReset |-> !sclkSync || $past(!sclkSync))
    else $error("serial reset without low clock");
  a_timeout_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    serialReset |=> !serialReset)
    else $error("serial reset held longer than one cycle");
endmodule : adc_conversion_sequencer

// ===== verification/host_spi_model.sv
// host side of the serial port: frames that read each new result
// assumes ref_clk-timed behaviour; sclk idles low and stands between frames
`timescale 1ns/1ps
module host_spi_model (
  // timing
  input wire logic ref_clk,
  // controls from the bench
  input wire logic pokeSclk,
  input wire logic stall,
  input wire logic holdCs,
  // device side
  input wire logic result_ready_low,
  output logic sclkPin,
  output logic csLowPin,
  output logic resReady
);
  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  // a stalled reader leaves results piling up in the fifo
  assign resReady = !stall;
  // one clock pulse is enough to take the ready flag back up
  initial begin
    sclkPin = 1'b0;
    csLowPin = 1'b1;
    forever begin
      @(posedge ref_clk);
      if (result_ready_low === 1'b0 || pokeSclk) begin
        #1 csLowPin = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 sclkPin = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 sclkPin = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 csLowPin = !holdCs;
      end
    end
  end
endmodule : host_spi_model

// ===== verification/adc_conversion_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer
// assumes host_spi_model and the rtl package; timeout shortened to 50
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top
  import adc_seq_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic singleMode = 1'b1;
  logic [2:0] rateSel = 3'h7;
  logic startWrite = 1'b0;
  logic modBit = 1'b1;
  logic stall = 1'b1;
  logic holdCs = 1'b0;
  logic pokeSclk = 1'b0;
  logic sclkPin, csLowPin, resReady;
  logic single_conversion_start, result_ready_low, poweredUp, converting;
  logic resValid, resDropped, serialReset;
  logic [RESULT_WIDTH-1:0] convResult, resData;
  int fail_count = 0;
  int n_compared = 0;

  always #25 ref_clk = ~ref_clk;

  adc_conversion_sequencer #(.TIMEOUT_CYC(50), .DEPTH(16))
    u_adc_conversion_sequencer (.ref_clk(ref_clk), .rst(rst),
    .singleMode(singleMode), .rateSel(rateSel), .startWrite(startWrite),
    .single_conversion_start(single_conversion_start), .modBit(modBit),
    .convResult(convResult), .result_ready_low(result_ready_low),
    .poweredUp(poweredUp), .converting(converting), .resValid(resValid),
    .resReady(resReady), .resData(resData), .resDropped(resDropped),
    .sclkPin(sclkPin), .csLowPin(csLowPin), .serialReset(serialReset));

  host_spi_model u_host_spi_model (.ref_clk(ref_clk), .pokeSclk(pokeSclk),
    .stall(stall), .holdCs(holdCs), .result_ready_low(result_ready_low),
    .sclkPin(sclkPin), .csLowPin(csLowPin), .resReady(resReady));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  // counts edges until the ready flag next falls
  task automatic wait_fall(output int n);
    n = 0;
    while (result_ready_low !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    while (result_ready_low !== 1'b0 && n < 50000) begin
      step(1);
      n++;
    end
  endtask : wait_fall

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    step(20);
    check({18'h0, single_conversion_start, result_ready_low, resValid,
      serialReset, poweredUp, converting}, 24'h000010);
    check(convResult, 24'h0);
    rst = 1'b0;
    $display("reset test done");
  endtask : test_reset

  task automatic test_timeout();
    int n;
    n = 0;
    while (serialReset !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    check({23'h0, serialReset}, 24'h1);
    step(30);
    pokeSclk = 1'b1;
    step(1);
    pokeSclk = 1'b0;
    n = 0;
    while (serialReset !== 1'b1 && n < 80) begin
      step(1);
      n++;
    end
    check({23'h0, n > 50}, 24'h1);
    check({23'h0, serialReset}, 24'h1);
    $display("timeout test done");
  endtask : test_timeout

  // reader stalls until the last check, so the result must wait in the fifo until released
  task automatic test_single();
    int n;
    startWrite = 1'b1;
    step(1);
    startWrite = 1'b0;
    step(1);
    check({23'h0, single_conversion_start}, 24'h1);
    n = 1;
    while (converting !== 1'b1 && n < 600) begin
      step(1);
      n++;
    end
    check(n[23:0], 24'(POWERUP_CYC + 1));
    check({23'h0, single_conversion_start}, 24'h0);
    startWrite = 1'b1;
    step(1);
    startWrite = 1'b0;
    wait_fall(n);
    step(3);
    check({23'h0, poweredUp}, 24'h0);
    check({22'h0, convResult[23], convResult == 24'h0}, 24'h0);
    check({23'h0, resValid}, 24'h1);
    check(resData, convResult);
    check({23'h0, resDropped}, 24'h0);
    step(600);
    check({22'h0, poweredUp, converting}, 24'h0);
    stall = 1'b0;
    step(3);
    check({23'h0, resValid}, 24'h0);
    $display("single test done");
  endtask : test_single

  task automatic test_cont();
    int n;
    int m;
    modBit = 1'b0;
    holdCs = 1'b1;
    singleMode = 1'b0;
    // convert starts one edge later; the rate moves four edges into it
    step(5);
    rateSel = 3'h6;
    wait_fall(n);
    m = n + 4;
    check(m[23:0], 24'd20000);
    wait_fall(n);
    check(n[23:0], 24'd40000);
    check({23'h0, convResult[23]}, 24'h1);
    $display("continuous test done");
  endtask : test_cont

  initial begin
    test_reset();
    test_timeout();
    test_single();
    test_cont();
    wrap_up();
  end

  // the scenarios need about 81000 cycles
  initial begin
    #(95000 * 50);
    fail_count++;
    wrap_up();
  end
endmodule : adc_conversion_sequencer_tb_top
